// file: fsps_pkg.sv
// Constants and types shared by the flash self-program sequencer
package fsps_pkg;
    localparam int ADDR_W = 14;
    localparam int DEPTH = 16384;
    localparam int PAGE_LSB = 9;
    localparam logic [13:0] FLASH_LAST = 14'h3fff;
    // Register select codes on the write port
    localparam logic [7:0] SFR_DATA = 8'he2;
    localparam logic [7:0] SFR_AHI = 8'he3;
    localparam logic [7:0] SFR_ALO = 8'he4;
    localparam logic [7:0] SFR_MODE = 8'he5;
    localparam logic [7:0] SFR_CTRL = 8'he6;
    localparam logic [7:0] SFR_CMD = 8'he7;
    // Reset values
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_AHI = 8'h00;
    localparam logic [7:0] RST_ALO = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // Unlock keys and control fields
    localparam logic [7:0] CMD_KEY1 = 8'h46;
    localparam logic [7:0] CMD_KEY2 = 8'hb9;
    localparam int CTRL_EN_BIT = 7;
    localparam logic [2:0] SWR_TO_APP = 3'h1;
    localparam logic [2:0] SWR_APP = 3'h5;
    localparam logic [2:0] SWR_LOADER = 3'h7;
    // Cycle counts, loaded as count minus one
    localparam logic [9:0] ERASE_CNT = 10'h1ff;
    localparam logic [9:0] PROG_CNT = 10'h003;
    localparam logic [9:0] READ_CNT = 10'h001;
    localparam logic [1:0] BOOT_SETTLE = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_READ = 2'h1,
        MODE_PROG = 2'h2,
        MODE_ERASE = 2'h3
    } fsps_mode_e;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_BUSY = 3'b100
    } fsps_state_e;
endpackage

// file: fsps_flash_if.sv
// Request and answer signals between sequencer and flash core
`timescale 1ns/1ps
interface fsps_flash_if;
    import fsps_pkg::*;
    logic start;
    fsps_mode_e op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output start, output op, output addr, output wdata, input done, input rdata);
    modport core (input start, input op, input addr, input wdata, output done, output rdata);
endinterface

// file: fsps_flash_core.sv
// Flash array with page erase, byte program and byte read engine
`timescale 1ns/1ps
module fsps_flash_core
    import fsps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    fsps_flash_if.core f
);
    logic [7:0] mem [DEPTH];
    logic busy_q, busy_d, done_q, done_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [9:0] cnt_q, cnt_d;
    fsps_mode_e op_q, op_d;
    logic [7:0] wd_q, wd_d, rd_q, rd_d;
    logic [7:0] cur_byte;

    assign cur_byte = mem[addr_q];
    assign f.done = done_q;
    assign f.rdata = rd_q;

    // Engine: latch request, count down, finish with a done pulse
    always_comb
    begin
        busy_d = busy_q;
        done_d = 1'b0;
        addr_d = addr_q;
        cnt_d = cnt_q;
        op_d = op_q;
        wd_d = wd_q;
        rd_d = rd_q;
        if (!busy_q)
        begin
            if (f.start)
            begin
                busy_d = 1'b1;
                op_d = f.op;
                addr_d = f.addr;
                wd_d = f.wdata;
                case (f.op)
                    MODE_ERASE: cnt_d = ERASE_CNT;
                    MODE_PROG: cnt_d = PROG_CNT;
                    default: cnt_d = READ_CNT;
                endcase
            end
        end
        else
        begin
            cnt_d = cnt_q - 10'h001;
            // Erase walks the page one byte per cycle
            if (op_q == MODE_ERASE)
                addr_d = addr_q + 14'h0001;
            if (cnt_q == 10'h000)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                if (op_q == MODE_READ)
                    rd_d = cur_byte;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= '0;
            cnt_q <= '0;
            op_q <= MODE_STANDBY;
            wd_q <= '0;
            rd_q <= ERASED_BYTE;
        end
        else if (ce)
        begin
            busy_q <= busy_d;
            done_q <= done_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
        end
    end

    // Array has no reset; programming can only pull bits low
    always_ff @(posedge clk)
    begin
        if (ce && busy_q)
        begin
            if (op_q == MODE_ERASE)
                mem[addr_q] <= ERASED_BYTE;
            else if (op_q == MODE_PROG && cnt_q == 10'h000)
                mem[addr_q] <= cur_byte & wd_q;
        end
    end

    prog_clear_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && busy_q && op_q == MODE_PROG && cnt_q == 10'h000)
        |=> ((mem[$past(addr_q)] & ~$past(cur_byte)) == 8'h00))
        else $error("program raised a flash bit");
    erase_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && f.start && !busy_q && f.op == MODE_ERASE) |=> (cnt_q == 10'h1ff))
        else $error("erase does not span one page");
endmodule // fsps_flash_core

// file: fsps_seq.sv
// Flash self-program sequencer: control registers, unlock, halt, boot
// Notes on behaviour
// - Programming only clears bits; erase sets them
// - Erase sets one aligned 512-byte page
// - Mode 3 erase, 2 program, 1 read, 0 standby
// - Control bit 7 enables the engine
// - Start needs 46h then B9h; CPU halts
// - Program writes data port to addressed byte
// - Read puts addressed byte into data port
// - Control bits 7..5 = 001 reboot application
// - Control bits 7..5 = 101 reboot application
// - 111 from application reboots into loader
// - Boot options select loader after power-on
// - Extra option adds loader boot on reset
// - Loader code addresses get start offset added
// - Enabled interrupts wait until operation completes
// - CPU frozen, not idled, during operation
// - CPU resumes at next instruction afterwards
// - Loader never modifies its own region
// - Loader targets beyond data region ignored
// - Erase ignores the low address byte
// - Application may only touch data region
`timescale 1ns/1ps
module fsps_seq
    import fsps_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic BOOT_FROM_LOADER_OPTION,
    input wire logic LOADER_BOOT_ON_EXT_RESET_OPTION,
    input wire logic LOADER_REGION_EN,
    input wire logic POWER_ON_FLAG,
    input wire logic [ADDR_W-1:0] LOADER_START,
    input wire logic [ADDR_W-1:0] DATA_LOW_BOUND,
    input wire logic [ADDR_W-1:0] CODE_ADDR,
    input wire logic [7:0] INT_REQ,
    input wire logic [7:0] INT_ENABLE,
    output logic [7:0] FLASH_ACCESS_CONTROL,
    output logic [7:0] FLASH_MODE_SELECT,
    output logic [7:0] FLASH_ADDR_HIGH,
    output logic [7:0] FLASH_ADDR_LOW,
    output logic [7:0] FLASH_DATA_PORT,
    output logic CPU_HALT,
    output logic SW_RESET,
    output logic IN_LOADER,
    output logic TRIGGER_IGNORED,
    output logic [ADDR_W-1:0] PHYS_CODE_ADDR,
    output logic [7:0] INT_TO_CPU
);
    fsps_flash_if fif ();

    logic rst_meta_q, rst_n_q;
    logic [3:0] pin_meta_q, pin_q;
    logic opt_boot, opt_ext, opt_loader, opt_por;
    fsps_state_e state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d, ahi_q, ahi_d, alo_q, alo_d;
    logic [7:0] data_q, data_d;
    logic armed_q, armed_d, start_q, start_d, halt_q, halt_d;
    logic swr_q, swr_d, ign_q, ign_d, loader_q, loader_d;
    logic [1:0] boot_cnt_q, boot_cnt_d;
    fsps_mode_e op_q, op_d, mode_op;
    logic [ADDR_W-1:0] tgt_q, tgt_d, tgt, data_high;
    logic [ADDR_W-1:0] pc_q, pc_d;
    logic [7:0] int_q, int_d;
    logic mode_ok, addr_ok, go_ok, cmd_wr, ctrl_wr;

    // Reset release is held off two edges to avoid a ragged exit
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Option pins are asynchronous straps; only pin_q is read
    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pin_meta_q <= 4'h0;
            pin_q <= 4'h0;
        end
        else if (CE)
        begin
            pin_meta_q <= {POWER_ON_FLAG, LOADER_REGION_EN,
                LOADER_BOOT_ON_EXT_RESET_OPTION, BOOT_FROM_LOADER_OPTION};
            pin_q <= pin_meta_q;
        end
    end
    assign opt_boot = pin_q[0];
    assign opt_ext = pin_q[1];
    assign opt_loader = pin_q[2];
    assign opt_por = pin_q[3];

    // Operation decode and target checks
    assign mode_op = fsps_mode_e'(mode_q[1:0]);
    assign mode_ok = (mode_q[7:2] == 6'h00) && (mode_op != MODE_STANDBY);
    assign tgt = (mode_op == MODE_ERASE) ? {ahi_q[5:1], 9'h000}
        : {ahi_q[5:0], alo_q};
    // Data region ends just below the loader region when one exists
    assign data_high = opt_loader ? LOADER_START - 14'h0001 : FLASH_LAST;
    assign addr_ok = (ahi_q[7:6] == 2'h0) && (tgt <= data_high)
        && (loader_q || tgt >= DATA_LOW_BOUND);
    assign go_ok = ctrl_q[CTRL_EN_BIT] && mode_ok && addr_ok;
    assign cmd_wr = SFR_WR && SFR_ADDR == SFR_CMD;
    assign ctrl_wr = SFR_WR && SFR_ADDR == SFR_CTRL;

    // Sequencer: register writes, unlock, halt and software reboot
    always_comb
    begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        mode_d = mode_q;
        ahi_d = ahi_q;
        alo_d = alo_q;
        data_d = data_q;
        armed_d = armed_q;
        start_d = 1'b0;
        halt_d = halt_q;
        swr_d = 1'b0;
        ign_d = 1'b0;
        loader_d = loader_q;
        boot_cnt_d = boot_cnt_q;
        op_d = op_q;
        tgt_d = tgt_q;
        case (state_q)
            ST_BOOT:
            begin
                // Wait for the strap synchroniser to fill, then pick region
                boot_cnt_d = boot_cnt_q + 2'h1;
                if (boot_cnt_q == BOOT_SETTLE)
                begin
                    loader_d = opt_boot && opt_loader && (opt_por || opt_ext);
                    halt_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (SFR_WR)
                begin
                    case (SFR_ADDR)
                        SFR_DATA: data_d = SFR_WDATA;
                        SFR_AHI: ahi_d = SFR_WDATA;
                        SFR_ALO: alo_d = SFR_WDATA;
                        SFR_MODE: mode_d = SFR_WDATA;
                        default: ;
                    endcase
                end
                if (cmd_wr)
                begin
                    armed_d = (SFR_WDATA == CMD_KEY1);
                    if (armed_q && SFR_WDATA == CMD_KEY2)
                    begin
                        if (go_ok)
                        begin
                            start_d = 1'b1;
                            halt_d = 1'b1;
                            op_d = mode_op;
                            tgt_d = tgt;
                            state_d = ST_BUSY;
                        end
                        else
                            ign_d = 1'b1;
                    end
                end
                if (ctrl_wr)
                begin
                    ctrl_d = SFR_WDATA;
                    if (SFR_WDATA[7:5] == SWR_TO_APP || SFR_WDATA[7:5] == SWR_APP
                        || (SFR_WDATA[7:5] == SWR_LOADER && !loader_q && opt_loader))
                    begin
                        // Reboot clears the sequencer as a CPU reset would
                        swr_d = 1'b1;
                        loader_d = (SFR_WDATA[7:5] == SWR_LOADER);
                        ctrl_d = RST_CTRL;
                        mode_d = RST_MODE;
                        ahi_d = RST_AHI;
                        alo_d = RST_ALO;
                        data_d = RST_DATA;
                        armed_d = 1'b0;
                    end
                end
            end
            ST_BUSY:
            begin
                // No writes can arrive here: the CPU is frozen
                if (fif.done)
                begin
                    halt_d = 1'b0;
                    state_d = ST_IDLE;
                    armed_d = 1'b0;
                    if (op_q == MODE_READ)
                        data_d = fif.rdata;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_BOOT;
            ctrl_q <= RST_CTRL;
            mode_q <= RST_MODE;
            ahi_q <= RST_AHI;
            alo_q <= RST_ALO;
            data_q <= RST_DATA;
            armed_q <= 1'b0;
            start_q <= 1'b0;
            halt_q <= 1'b1;
            swr_q <= 1'b0;
            ign_q <= 1'b0;
            loader_q <= 1'b0;
            boot_cnt_q <= 2'h0;
            op_q <= MODE_STANDBY;
            tgt_q <= '0;
        end
        else if (CE)
        begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            ahi_q <= ahi_d;
            alo_q <= alo_d;
            data_q <= data_d;
            armed_q <= armed_d;
            start_q <= start_d;
            halt_q <= halt_d;
            swr_q <= swr_d;
            ign_q <= ign_d;
            loader_q <= loader_d;
            boot_cnt_q <= boot_cnt_d;
            op_q <= op_d;
            tgt_q <= tgt_d;
        end
    end

    // Code relocation and interrupt hold-off, registered for clean outputs
    always_comb
    begin
        pc_d = loader_d ? CODE_ADDR + LOADER_START : CODE_ADDR;
        // Requests that vanish while halted are simply lost
        int_d = halt_d ? 8'h00 : (INT_REQ & INT_ENABLE);
    end

    always_ff @(posedge CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pc_q <= '0;
            int_q <= 8'h00;
        end
        else if (CE)
        begin
            pc_q <= pc_d;
            int_q <= int_d;
        end
    end

    assign fif.start = start_q;
    assign fif.op = op_q;
    assign fif.addr = tgt_q;
    assign fif.wdata = data_q;

    fsps_flash_core u_core (
        .clk(CLK),
        .rst_n(rst_n_q),
        .ce(CE),
        .f(fif)
    );

    assign FLASH_ACCESS_CONTROL = ctrl_q;
    assign FLASH_MODE_SELECT = mode_q;
    assign FLASH_ADDR_HIGH = ahi_q;
    assign FLASH_ADDR_LOW = alo_q;
    assign FLASH_DATA_PORT = data_q;
    assign CPU_HALT = halt_q;
    assign SW_RESET = swr_q;
    assign IN_LOADER = loader_q;
    assign TRIGGER_IGNORED = ign_q;
    assign PHYS_CODE_ADDR = pc_q;
    assign INT_TO_CPU = int_q;

    default clocking dc @(posedge CLK); endclocking
    default disable iff (!rst_n_q);

    sequence key_pair_s;
        CE && state_q == ST_IDLE && cmd_wr && armed_q && SFR_WDATA == CMD_KEY2;
    endsequence
    sequence done_s;
        CE && state_q == ST_BUSY && fif.done;
    endsequence

    start_needs_key_a: assert property ($rose(start_q) |-> $past(armed_q))
        else $error("start without unlock key");
    good_key_starts_a: assert property (key_pair_s ##0 go_ok |=> start_q && CPU_HALT)
        else $error("valid trigger did not start");
    bad_trigger_dropped_a: assert property (key_pair_s ##0 !go_ok
        |=> !start_q && TRIGGER_IGNORED && state_q == ST_IDLE)
        else $error("invalid trigger not ignored");
    halt_while_busy_a: assert property (state_q == ST_BUSY |-> CPU_HALT)
        else $error("CPU runs during operation");
    resume_on_done_a: assert property (done_s |=> !CPU_HALT ##0 state_q == ST_IDLE)
        else $error("CPU not resumed after done");
    read_lands_a: assert property (done_s ##0 op_q == MODE_READ
        |=> FLASH_DATA_PORT == $past(fif.rdata))
        else $error("read byte not in data port");
    erase_page_a: assert property (start_q && op_q == MODE_ERASE |-> tgt_q[8:0] == 9'h000)
        else $error("erase not page aligned");
    ints_held_a: assert property (CPU_HALT |-> INT_TO_CPU == 8'h00)
        else $error("interrupt passed while halted");
    swreset_app_a: assert property (CE && state_q == ST_IDLE && ctrl_wr
        && SFR_WDATA[7:5] == SWR_APP |=> SW_RESET && !IN_LOADER)
        else $error("reboot to application failed");
    swreset_loader_a: assert property (CE && state_q == ST_IDLE && ctrl_wr
        && SFR_WDATA[7:5] == SWR_LOADER && !loader_q && opt_loader |=> SW_RESET && IN_LOADER)
        else $error("reboot to loader failed");
    code_offset_a: assert property (CE && loader_d
        |=> PHYS_CODE_ADDR == 14'($past(CODE_ADDR) + $past(LOADER_START)))
        else $error("loader code not relocated");
endmodule // fsps_seq

// file: testbench.sv
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ps
module testbench;
    import fsps_pkg::*;
    logic clk, reset_n, ce, sfr_wr, boot_opt, ext_opt, region_en, power_on;
    logic [7:0] sfr_addr, sfr_wdata, int_req, int_en;
    logic [13:0] loader_start, data_low, code_addr;
    logic [7:0] ctrl, mode, ahi, alo, dport, int_cpu;
    logic halt, swr, in_ldr, ign;
    logic [13:0] phys;
    int err_count, total_checks;

    fsps_seq dut_u (.CLK(clk), .RESET_N(reset_n), .CE(ce), .SFR_WR(sfr_wr),
        .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .BOOT_FROM_LOADER_OPTION(boot_opt),
        .LOADER_BOOT_ON_EXT_RESET_OPTION(ext_opt), .LOADER_REGION_EN(region_en),
        .POWER_ON_FLAG(power_on), .LOADER_START(loader_start), .DATA_LOW_BOUND(data_low),
        .CODE_ADDR(code_addr), .INT_REQ(int_req), .INT_ENABLE(int_en),
        .FLASH_ACCESS_CONTROL(ctrl), .FLASH_MODE_SELECT(mode), .FLASH_ADDR_HIGH(ahi),
        .FLASH_ADDR_LOW(alo), .FLASH_DATA_PORT(dport), .CPU_HALT(halt), .SW_RESET(swr),
        .IN_LOADER(in_ldr), .TRIGGER_IGNORED(ign), .PHYS_CODE_ADDR(phys),
        .INT_TO_CPU(int_cpu));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One register write; returns just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    // Bounded wait until the CPU is released again
    task automatic wait_run();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (halt !== 1'b0 && n < 50);
        chk(halt, 1'b0);
    endtask

    // Full operation; n is the expected halt length, 0 means a refused trigger
    task automatic op(input logic [7:0] m, input logic [7:0] ah, input logic [7:0] al,
                      input logic [7:0] d, input int n);
        int cyc;
        wr(SFR_MODE, m);
        wr(SFR_AHI, ah);
        wr(SFR_ALO, al);
        wr(SFR_DATA, d);
        wr(SFR_CMD, CMD_KEY1);
        wr(SFR_CMD, CMD_KEY2);
        #1;
        if (n == 0)
        begin
            chk(ign, 1'b1);
            chk(halt, 1'b0);
        end
        else
        begin
            cyc = 0;
            chk(halt, 1'b1);
            while (halt === 1'b1 && cyc < 600)
            begin
                @(posedge clk);
                #1;
                cyc++;
                if (halt === 1'b1)
                    chk(int_cpu, 8'h00);
            end
            chk(cyc[15:0], n[15:0]);
            @(posedge clk);
            #1;
            chk(int_cpu, 8'h0c);
        end
        // Back to standby after every operation
        wr(SFR_MODE, 8'h00);
    endtask

    // Reset with the given strap levels
    task automatic rst(input logic b, input logic e, input logic p, input logic exp_ldr);
        @(posedge clk);
        reset_n <= 1'b0;
        boot_opt <= b;
        ext_opt <= e;
        power_on <= p;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        wait_run();
        chk(in_ldr, exp_ldr);
    endtask

    // Software reboot through the control register
    task automatic reb(input logic [7:0] d, input logic exp_ldr);
        wr(SFR_CTRL, d);
        #1;
        chk(swr, 1'b1);
        chk(in_ldr, exp_ldr);
        wait_run();
        chk(ahi, RST_AHI);
    endtask

    task automatic t_phys(input logic [13:0] exp);
        @(posedge clk);
        code_addr <= 14'h0012;
        @(posedge clk);
        #1;
        chk(phys, exp);
    endtask

    // Erase, program, overwrite and misaligned erase, each read back
    task automatic t_flash();
        wr(SFR_CTRL, 8'h80);
        op(8'h03, 8'h02, 8'h00, 8'h00, 514);
        op(8'h01, 8'h02, 8'h05, 8'h00, 4);
        chk(dport, ERASED_BYTE);
        op(8'h02, 8'h02, 8'h05, 8'ha5, 6);
        op(8'h01, 8'h02, 8'h05, 8'h00, 4);
        chk(dport, 8'ha5);
        op(8'h02, 8'h02, 8'h05, 8'h0f, 6);
        op(8'h01, 8'h02, 8'h05, 8'h00, 4);
        chk(dport, 8'h05);
        op(8'h03, 8'h03, 8'h55, 8'h00, 514);
        op(8'h01, 8'h02, 8'h05, 8'h00, 4);
        chk(dport, 8'hff);
    endtask

    // Clock enable low after the trigger stretches the halt by the frozen cycles
    task automatic t_freeze();
        int cyc;
        wr(SFR_MODE, 8'h01);
        wr(SFR_AHI, 8'h02);
        wr(SFR_ALO, 8'h05);
        wr(SFR_CMD, CMD_KEY1);
        wr(SFR_CMD, CMD_KEY2);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        #1;
        chk(halt, 1'b1);
        cyc = 0;
        while (halt === 1'b1 && cyc < 50)
        begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk(cyc[15:0], 16'h0004);
        chk(dport, ERASED_BYTE);
        wr(SFR_MODE, 8'h00);
    endtask

    // Refused triggers: disabled, standby, broken key, loader region target
    task automatic t_reject();
        wr(SFR_CTRL, 8'h00);
        op(8'h01, 8'h02, 8'h05, 8'h00, 0);
        wr(SFR_CTRL, 8'h80);
        op(8'h00, 8'h02, 8'h05, 8'h00, 0);
        op(8'h01, 8'h3a, 8'h00, 8'h00, 0);
        op(8'h03, 8'h3c, 8'h00, 8'h00, 0);
        // Target in range, so only the broken key can stop this one
        wr(SFR_AHI, 8'h02);
        wr(SFR_MODE, 8'h01);
        wr(SFR_CMD, CMD_KEY1);
        wr(SFR_CMD, 8'h00);
        wr(SFR_CMD, CMD_KEY2);
        #1;
        chk(halt, 1'b0);
        chk(ign, 1'b0);
        wr(SFR_MODE, 8'h00);
    endtask

    // Application side: only the data region is reachable
    task automatic t_app();
        wr(SFR_CTRL, 8'h80);
        op(8'h01, 8'h02, 8'h05, 8'h00, 0);
        // Erase first so the read sees defined contents
        op(8'h03, 8'h36, 8'h00, 8'h00, 514);
        op(8'h01, 8'h36, 8'h00, 8'h00, 4);
        chk(dport, ERASED_BYTE);
        op(8'h01, 8'h3a, 8'h00, 8'h00, 0);
    endtask

    // Hang guard, far above the roughly two thousand cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        err_count = 0;
        total_checks = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        sfr_wr = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        boot_opt = 1'b1;
        ext_opt = 1'b0;
        region_en = 1'b1;
        power_on = 1'b1;
        loader_start = 14'h3a00;
        data_low = 14'h3600;
        code_addr = 14'h0000;
        int_req = 8'h3c;
        int_en = 8'h0f;
        rst(1'b1, 1'b0, 1'b1, 1'b1);
        chk({ctrl, mode}, {RST_CTRL, RST_MODE});
        chk({ahi, alo}, {RST_AHI, RST_ALO});
        chk(dport, RST_DATA);
        t_phys(14'h3a12);
        t_flash();
        t_freeze();
        t_reject();
        reb(8'h20, 1'b0);
        t_phys(14'h0012);
        t_app();
        reb(8'he0, 1'b1);
        reb(8'ha0, 1'b0);
        rst(1'b1, 1'b1, 1'b0, 1'b1);
        rst(1'b1, 1'b0, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule // testbench
